// file: option_loader_defs.svh
// option loader constants: indices, field positions, reset values, counts
// assumes inclusion by bare name from every file that needs the numbers
`ifndef OPTION_LOADER_DEFS_SVH
`define OPTION_LOADER_DEFS_SVH

// option indices, also the byte addresses in the option storage
`define OPT_IDX_TRIM   8'h83
`define OPT_IDX_CFG0   8'hc1
`define OPT_IDX_CFG1   8'hc2

// option_config_0 fields
`define CFG0_WDT_BIT     7
`define CFG0_DIV_HI      5
`define CFG0_DIV_LO      4
`define CFG0_RSTPIN_BIT  3
`define CFG0_BOR_DIS_BIT 2
`define CFG0_BOR_LVL_HI  1
`define CFG0_BOR_LVL_LO  0
`define CFG0_WMASK       8'hbf

// option_config_1 fields
`define CFG1_REF_HI    7
`define CFG1_REF_LO    6
`define CFG1_BOOT_BIT  5
`define CFG1_DBG_BIT   4
`define CFG1_IAP_HI    3
`define CFG1_IAP_LO    2
`define CFG1_LDS_HI    1
`define CFG1_LDS_LO    0

// reset values before the load completes
`define OPT_RESET_VAL  8'h00
`define SFR_INDEX_RST  8'h00

// oscillator divide ratios for codes 00, 01, 10, 11
`define DIV_RATIO_0    4'h1
`define DIV_RATIO_1    4'h2
`define DIV_RATIO_2    4'h4
`define DIV_RATIO_3    4'hc

// load sequence length, three options at three cycles each
`define LOAD_CYCLES    9
`define LOAD_LAST_SLOT 2'h2

// protected head of the main program area
`define MOVC_GUARD_BYTES 14'h0100

`endif

// file: option_loader_pkg.sv
// types shared by the option loader and its helper modules
// assumes nothing beyond a SystemVerilog compiler
package option_loader_pkg;

  // special-function-register access from the core, one cycle strobes
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       sel_data;   // 0 index register, 1 data register
    logic [7:0] wdata;
  } sfr_req_type;

  // program-memory read request as seen by the read guard
  typedef struct packed {
    logic        req;
    logic        target_loader;   // address lies in boot loader area
    logic        exec_loader;     // requesting code runs in loader area
    logic [13:0] addr;            // offset within the target area
  } movc_req_type;

  typedef enum logic [1:0] {
    LD_FETCH   = 2'b00,
    LD_WAIT    = 2'b01,
    LD_CAPTURE = 2'b10,
    LD_RUN     = 2'b11
  } load_state_type;

  typedef struct packed {
    load_state_type state;
    logic [1:0]     slot;
    logic           nvm_rd;
    logic [7:0]     nvm_addr;
    logic [7:0]     index;
    logic [7:0]     cfg0;
    logic [7:0]     cfg1;
    logic [7:0]     trim;
    logic [7:0]     rdata;
    logic [2:0]     pin_sync;
    logic           pin_level;
    logic           ext_reset;
    logic           gpio_in;
    logic           bor_en;
    logic           done;
  } loader_state_type;

  typedef struct packed {
    logic [3:0] count;
    logic       tick;
  } divider_state_type;

  typedef struct packed {
    logic valid;
    logic blocked;
  } guard_state_type;

endpackage

// file: sys_clock_divider.sv
// system clock strobe: divides the oscillator clock by 1, 2, 4 or 12
// assumes i_clk is the high-frequency oscillator and the select is stable
`timescale 1ns/1ps
`include "option_loader_defs.svh"

module sys_clock_divider (
  input  logic       i_clk,
  input  logic       i_resetn,
  input  logic       i_run,
  input  logic [1:0] i_divider_select,
  output logic       o_sys_clk_tick
);

  option_loader_pkg::divider_state_type r_reg;
  option_loader_pkg::divider_state_type r_next;

  // code to ratio, shared by the counter and its check
  function automatic logic [3:0] ratio_of(input logic [1:0] sel);
    case (sel)
      2'h0:    ratio_of = `DIV_RATIO_0;
      2'h1:    ratio_of = `DIV_RATIO_1;
      2'h2:    ratio_of = `DIV_RATIO_2;
      default: ratio_of = `DIV_RATIO_3;
    endcase
  endfunction

  // one tick per ratio cycles; idle until the options are loaded
  always_comb begin
    r_next = r_reg;
    if (!i_run) begin
      r_next.count = 4'h0;
      r_next.tick  = 1'b0;
    end else if (r_reg.count >= ratio_of(i_divider_select) - 4'h1) begin
      r_next.count = 4'h0;
      r_next.tick  = 1'b1;
    end else begin
      r_next.count = r_reg.count + 4'h1;
      r_next.tick  = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_sys_clk_tick = r_reg.tick;

  // a code change may leave a stale count that ticks once early, so the
  // spacing is only checked once the code has stood for two samples
  a_div_tick_spacing: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_sys_clk_tick && $past(i_run) && $stable(i_divider_select) &&
    $past(i_divider_select, 2) == i_divider_select |->
      $past(r_reg.count) == ratio_of(i_divider_select) - 4'h1)
    else $error("divider tick at wrong count");

  a_div_by_one: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_run && i_divider_select == 2'h0 |=> o_sys_clk_tick)
    else $error("divide by one missed a tick");

endmodule

// file: program_read_guard.sv
// program-memory read guard for code running in the main area
// assumes one request per cycle and a registered verdict is acceptable
`timescale 1ns/1ps
`include "option_loader_defs.svh"

module program_read_guard (
  input  logic                           i_clk,
  input  logic                           i_resetn,
  input  option_loader_pkg::movc_req_type i_movc,
  output logic                           o_movc_valid,
  output logic                           o_movc_blocked
);

  option_loader_pkg::guard_state_type r_reg;
  option_loader_pkg::guard_state_type r_next;

  // main-area code may not see the loader nor the head of its own area
  always_comb begin
    r_next.valid   = i_movc.req;
    r_next.blocked = i_movc.req && !i_movc.exec_loader &&
                     (i_movc.target_loader ||
                      i_movc.addr < `MOVC_GUARD_BYTES);
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_movc_valid   = r_reg.valid;
  assign o_movc_blocked = r_reg.blocked;

  a_movc_head_block: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_movc.req && !i_movc.exec_loader && !i_movc.target_loader &&
    i_movc.addr == 14'h00ff |=> o_movc_valid && o_movc_blocked)
    else $error("head of main area readable");

  a_movc_loader_block: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_movc.req && !i_movc.exec_loader && i_movc.target_loader
    |=> o_movc_blocked)
    else $error("loader area readable from main code");

  a_movc_pass: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_movc.req && !i_movc.target_loader &&
    i_movc.addr == `MOVC_GUARD_BYTES |=> o_movc_valid && !o_movc_blocked)
    else $error("open address was blocked");

endmodule

// file: code_option_loader.sv
// option loader: copies the option bytes from storage at reset and
// serves them to software through an index and a data register
// assumes a storage that answers one cycle after its read strobe
`timescale 1ns/1ps
`include "option_loader_defs.svh"

module code_option_loader (
  input  logic                             i_clk,
  input  logic                             i_resetn,
  input  option_loader_pkg::sfr_req_type   i_sfr,
  output logic [7:0]                       o_sfr_rdata,
  output logic                             o_nvm_rd,
  output logic [7:0]                       o_nvm_addr,
  input  logic [7:0]                       i_nvm_rdata,
  input  logic                             i_reset_pin,
  input  option_loader_pkg::movc_req_type  i_movc,
  output logic                             o_movc_valid,
  output logic                             o_movc_blocked,
  output logic                             o_load_done,
  output logic                             o_watchdog_enable,
  output logic                             o_sys_clk_tick,
  output logic                             o_ext_reset_req,
  output logic                             o_gpio_in,
  output logic                             o_brownout_enable,
  output logic [1:0]                       o_brownout_level_select,
  output logic [1:0]                       o_converter_reference_select,
  output logic                             o_boot_from_loader,
  output logic                             o_debug_port_disable,
  output logic [1:0]                       o_self_program_range,
  output logic [1:0]                       o_boot_area_size,
  output logic [7:0]                       o_oscillator_trim
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------

  // pin stages start high so a released reset line raises no request
  localparam option_loader_pkg::loader_state_type STATE_RESET = '{
    state:     option_loader_pkg::LD_FETCH,
    slot:      2'h0,
    nvm_rd:    1'h0,
    nvm_addr:  8'h00,
    index:     `SFR_INDEX_RST,
    cfg0:      `OPT_RESET_VAL,
    cfg1:      `OPT_RESET_VAL,
    trim:      `OPT_RESET_VAL,
    rdata:     8'h00,
    pin_sync:  3'h7,
    pin_level: 1'h1,
    ext_reset: 1'h0,
    gpio_in:   1'h0,
    bor_en:    1'h1,
    done:      1'h0
  };

  option_loader_pkg::loader_state_type r_reg;
  option_loader_pkg::loader_state_type r_next;

  // slot order of the load: trim, config 0, config 1
  function automatic logic [7:0] slot_index(input logic [1:0] slot);
    case (slot)
      2'h0:    slot_index = `OPT_IDX_TRIM;
      2'h1:    slot_index = `OPT_IDX_CFG0;
      default: slot_index = `OPT_IDX_CFG1;
    endcase
  endfunction

  // index decode for reads and writes: {hit, slot}
  function automatic logic [2:0] decode_index(input logic [7:0] idx);
    case (idx)
      `OPT_IDX_TRIM: decode_index = 3'h4;
      `OPT_IDX_CFG0: decode_index = 3'h5;
      `OPT_IDX_CFG1: decode_index = 3'h6;
      default:       decode_index = 3'h0;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------------

  // load sequence, software access, pin role and derived levels
  always_comb begin
    logic [2:0] dec;
    logic [7:0] opt_val;
    logic [1:0] wslot;
    logic [7:0] wval;
    logic       wen;
    dec     = decode_index(r_reg.index);
    opt_val = 8'h00;
    wslot   = 2'h0;
    wval    = 8'h00;
    wen     = 1'b0;
    r_next  = r_reg;

    // level follows the third stage only while second and third stages agree
    r_next.pin_sync = {r_reg.pin_sync[1:0], i_reset_pin};
    if (r_reg.pin_sync[1] == r_reg.pin_sync[2]) begin
      r_next.pin_level = r_reg.pin_sync[2];
    end
    r_next.ext_reset = !r_reg.cfg0[`CFG0_RSTPIN_BIT] &&
                       !r_reg.pin_level;
    r_next.gpio_in   = r_reg.cfg0[`CFG0_RSTPIN_BIT] &&
                       r_reg.pin_level;

    case (dec[1:0])
      2'h0:    opt_val = r_reg.trim;
      2'h1:    opt_val = r_reg.cfg0;
      default: opt_val = r_reg.cfg1;
    endcase

    r_next.nvm_rd = 1'b0;
    case (r_reg.state)
      option_loader_pkg::LD_FETCH: begin
        r_next.nvm_rd   = 1'b1;
        r_next.nvm_addr = slot_index(r_reg.slot);
        r_next.state    = option_loader_pkg::LD_WAIT;
      end
      option_loader_pkg::LD_WAIT: begin
        r_next.state = option_loader_pkg::LD_CAPTURE;
      end
      option_loader_pkg::LD_CAPTURE: begin
        wen   = 1'b1;
        wslot = r_reg.slot;
        wval  = i_nvm_rdata;
        if (r_reg.slot == `LOAD_LAST_SLOT) begin
          r_next.state = option_loader_pkg::LD_RUN;
          r_next.done  = 1'b1;
        end else begin
          r_next.slot  = r_reg.slot + 2'h1;
          r_next.state = option_loader_pkg::LD_FETCH;
        end
      end
      option_loader_pkg::LD_RUN: begin
        // data writes reach only a mapped option
        if (i_sfr.wr && i_sfr.sel_data && dec[2]) begin
          wen   = 1'b1;
          wslot = dec[1:0];
          wval  = i_sfr.wdata;
        end
      end
      default: begin
        r_next.state = option_loader_pkg::LD_FETCH;
      end
    endcase

    // the index is open from reset on, unlike the data register
    if (i_sfr.wr && !i_sfr.sel_data) begin
      r_next.index = i_sfr.wdata;
    end

    // one write path for the load and for software
    if (wen) begin
      case (wslot)
        2'h0:    r_next.trim = wval;
        2'h1:    r_next.cfg0 = wval & `CFG0_WMASK;
        default: r_next.cfg1 = wval;
      endcase
    end

    // data reads before the load completes or of a hole return zero
    if (i_sfr.rd) begin
      if (!i_sfr.sel_data) begin
        r_next.rdata = r_reg.index;
      end else if (r_reg.done && dec[2]) begin
        r_next.rdata = opt_val;
      end else begin
        r_next.rdata = 8'h00;
      end
    end

    r_next.bor_en = !r_next.cfg0[`CFG0_BOR_DIS_BIT];
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r_reg <= STATE_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // --------------------------------------------------------------------
  // helpers and outputs
  // --------------------------------------------------------------------

  // divider waits for the load so it never runs on a stale code
  sys_clock_divider u_divider (
    .i_clk            (i_clk),
    .i_resetn         (i_resetn),
    .i_run            (r_reg.done),
    .i_divider_select (r_reg.cfg0[`CFG0_DIV_HI:`CFG0_DIV_LO]),
    .o_sys_clk_tick   (o_sys_clk_tick)
  );

  program_read_guard u_guard (
    .i_clk          (i_clk),
    .i_resetn       (i_resetn),
    .i_movc         (i_movc),
    .o_movc_valid   (o_movc_valid),
    .o_movc_blocked (o_movc_blocked)
  );

  // option fields straight from their flip-flops
  assign o_sfr_rdata       = r_reg.rdata;
  assign o_nvm_rd          = r_reg.nvm_rd;
  assign o_nvm_addr        = r_reg.nvm_addr;
  assign o_load_done       = r_reg.done;
  assign o_watchdog_enable = r_reg.cfg0[`CFG0_WDT_BIT];
  assign o_ext_reset_req   = r_reg.ext_reset;
  assign o_gpio_in         = r_reg.gpio_in;
  assign o_brownout_enable = r_reg.bor_en;
  assign o_brownout_level_select =
    r_reg.cfg0[`CFG0_BOR_LVL_HI:`CFG0_BOR_LVL_LO];
  assign o_converter_reference_select =
    r_reg.cfg1[`CFG1_REF_HI:`CFG1_REF_LO];
  assign o_boot_from_loader   = r_reg.cfg1[`CFG1_BOOT_BIT];
  assign o_debug_port_disable = r_reg.cfg1[`CFG1_DBG_BIT];
  assign o_self_program_range = r_reg.cfg1[`CFG1_IAP_HI:`CFG1_IAP_LO];
  assign o_boot_area_size     = r_reg.cfg1[`CFG1_LDS_HI:`CFG1_LDS_LO];
  assign o_oscillator_trim    = r_reg.trim;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------

  default clocking cb_main @(posedge i_clk);
  endclocking

  default disable iff (!i_resetn);

  sequence s_fetch(logic [7:0] idx);
    o_nvm_rd && o_nvm_addr == idx;
  endsequence

  sequence s_load_start;
    r_reg.state == option_loader_pkg::LD_FETCH && r_reg.slot == 2'h0;
  endsequence

  a_load_cfg0: assert property (
    s_fetch(`OPT_IDX_CFG0) |->
      ##2 r_reg.cfg0 == ($past(i_nvm_rdata) & `CFG0_WMASK))
    else $error("config 0 not loaded from storage");

  a_load_trim: assert property (
    s_fetch(`OPT_IDX_TRIM) |-> ##2 o_oscillator_trim == $past(i_nvm_rdata))
    else $error("trim not loaded from storage");

  a_load_done_time: assert property (
    s_load_start |-> !o_load_done [*8] ##1 !o_load_done ##1 o_load_done)
    else $error("load did not finish in nine cycles");

  a_index_write: assert property (
    i_sfr.wr && !i_sfr.sel_data |=> r_reg.index == $past(i_sfr.wdata))
    else $error("index register not written");

  a_cfg1_write: assert property (
    o_load_done && i_sfr.wr && i_sfr.sel_data &&
    r_reg.index == `OPT_IDX_CFG1 |=>
      o_converter_reference_select == $past(i_sfr.wdata[7:6]) &&
      o_boot_from_loader == $past(i_sfr.wdata[5]))
    else $error("config 1 write lost");

  a_data_read: assert property (
    o_load_done && i_sfr.rd && i_sfr.sel_data &&
    r_reg.index == `OPT_IDX_CFG0 |=> o_sfr_rdata == $past(r_reg.cfg0))
    else $error("data read returned wrong option");

  a_bit6_zero: assert property (
    i_sfr.rd && i_sfr.sel_data && r_reg.index == `OPT_IDX_CFG0
    |=> o_sfr_rdata[6] == 1'b0)
    else $error("unassigned bit reads one");

  a_pin_role: assert property (
    o_ext_reset_req |-> !$past(o_gpio_in) && !$past(r_reg.cfg0[3]))
    else $error("reset request while pin is GPIO");

  a_brownout_on: assert property (
    $fell(r_reg.cfg0[`CFG0_BOR_DIS_BIT]) |-> o_brownout_enable)
    else $error("brownout not enabled with disable clear");

endmodule

// file: code_option_loader_tb.sv
// self-checking bench for the option loader: storage load, index/data
// access, divider, pin choice and program read guard against a model
// assumes the design files and option_loader_defs.svh are compiled first
`timescale 1ns/1ps
`include "option_loader_defs.svh"

module code_option_loader_tb;

  // ------------------------------------------------------------------
  // signals and model state
  // ------------------------------------------------------------------
  logic                            i_clk;
  logic                            i_resetn;
  option_loader_pkg::sfr_req_type  sfr_in;
  option_loader_pkg::movc_req_type movc_in;
  logic [7:0]  o_sfr_rdata;
  logic        o_nvm_rd;
  logic [7:0]  o_nvm_addr;
  logic [7:0]  nvm_rdata;
  logic        reset_pin;
  logic        o_movc_valid;
  logic        o_movc_blocked;
  logic        o_load_done;
  logic        o_watchdog_enable;
  logic        o_sys_clk_tick;
  logic        o_ext_reset_req;
  logic        o_gpio_in;
  logic        o_brownout_enable;
  logic [1:0]  o_brownout_level_select;
  logic [1:0]  o_converter_reference_select;
  logic        o_boot_from_loader;
  logic        o_debug_port_disable;
  logic [1:0]  o_self_program_range;
  logic [1:0]  o_boot_area_size;
  logic [7:0]  o_oscillator_trim;
  logic [7:0]  mem [0:255];
  logic [7:0]  m0;
  logic [7:0]  m1;
  logic [7:0]  mt;
  logic        hold;
  logic [7:0]  hold_addr;
  int          cyc;
  int          rd_cyc [$];
  logic [7:0]  rd_addr [$];
  int          fails;
  int          n_tests;
  int          seed;

  code_option_loader i_dut (
    .i_clk                        (i_clk),
    .i_resetn                     (i_resetn),
    .i_sfr                        (sfr_in),
    .o_sfr_rdata                  (o_sfr_rdata),
    .o_nvm_rd                     (o_nvm_rd),
    .o_nvm_addr                   (o_nvm_addr),
    .i_nvm_rdata                  (nvm_rdata),
    .i_reset_pin                  (reset_pin),
    .i_movc                       (movc_in),
    .o_movc_valid                 (o_movc_valid),
    .o_movc_blocked               (o_movc_blocked),
    .o_load_done                  (o_load_done),
    .o_watchdog_enable            (o_watchdog_enable),
    .o_sys_clk_tick               (o_sys_clk_tick),
    .o_ext_reset_req              (o_ext_reset_req),
    .o_gpio_in                    (o_gpio_in),
    .o_brownout_enable            (o_brownout_enable),
    .o_brownout_level_select      (o_brownout_level_select),
    .o_converter_reference_select (o_converter_reference_select),
    .o_boot_from_loader           (o_boot_from_loader),
    .o_debug_port_disable         (o_debug_port_disable),
    .o_self_program_range         (o_self_program_range),
    .o_boot_area_size             (o_boot_area_size),
    .o_oscillator_trim            (o_oscillator_trim)
  );

  // ------------------------------------------------------------------
  // clock, storage stand-in, load monitor
  // ------------------------------------------------------------------
  initial i_clk = 1'b0;
  always #10 i_clk = ~i_clk;

  // storage answers for one cycle, then shows toggling junk so a late
  // capture cannot pick up a stale byte by luck
  always @(posedge i_clk) begin
    hold <= o_nvm_rd;
    hold_addr <= o_nvm_addr;
  end
  always @(negedge i_clk) begin
    if (hold === 1'b1) nvm_rdata <= mem[hold_addr];
    else nvm_rdata <= ~nvm_rdata;
  end

  // record in which cycle after release each storage read is issued
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) cyc <= 0;
    else begin
      cyc <= cyc + 1;
      if (o_nvm_rd === 1'b1) begin
        rd_cyc.push_back(cyc);
        rd_addr.push_back(o_nvm_addr);
      end
    end
  end

  // ------------------------------------------------------------------
  // compare, access and closing tasks
  // ------------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // one strobe, then a free cycle so strobes never merge
  task automatic sfr_acc(input logic w, input logic sel,
                         input logic [7:0] d);
    sfr_in = '{wr: w, rd: !w, sel_data: sel, wdata: d};
    @(negedge i_clk);
    sfr_in = '0;
    @(negedge i_clk);
  endtask

  function automatic logic [7:0] model_rd(input logic [7:0] idx);
    case (idx)
      `OPT_IDX_CFG0: return m0;
      `OPT_IDX_CFG1: return m1;
      `OPT_IDX_TRIM: return mt;
      default:       return 8'h00;
    endcase
  endfunction

  task automatic rdreg(input logic [7:0] idx);
    sfr_acc(1'b1, 1'b0, idx);
    sfr_acc(1'b0, 1'b1, 8'h00);
    chk8(o_sfr_rdata, model_rd(idx), "option read");
  endtask

  task automatic wrreg(input logic [7:0] idx, input logic [7:0] v);
    sfr_acc(1'b1, 1'b0, idx);
    sfr_acc(1'b1, 1'b1, v);
    if (idx == `OPT_IDX_CFG0) m0 = v & 8'hbf;
    if (idx == `OPT_IDX_CFG1) m1 = v;
    if (idx == `OPT_IDX_TRIM) mt = v;
  endtask

  task automatic chk_out;
    chk8({7'h0, o_watchdog_enable}, {7'h0, m0[7]}, "wdt");
    chk8({7'h0, o_brownout_enable}, {7'h0, !m0[2]}, "bor");
    chk8({6'h0, o_brownout_level_select}, {6'h0, m0[1:0]}, "lvl");
    chk8({6'h0, o_converter_reference_select}, {6'h0, m1[7:6]},
         "ref");
    chk8({7'h0, o_boot_from_loader}, {7'h0, m1[5]}, "boot");
    chk8({4'h0, o_debug_port_disable, o_self_program_range,
          o_boot_area_size}, {4'h0, m1[4:0]}, "cfg1 low");
    chk8(o_oscillator_trim, mt, "trim");
  endtask

  // reset with fresh storage contents, then time the load
  task automatic do_reset;
    int n;
    i_resetn = 1'b0;
    repeat (5) @(negedge i_clk);
    mem[`OPT_IDX_TRIM] = 8'($random(seed));
    mem[`OPT_IDX_CFG0] = 8'($random(seed));
    mem[`OPT_IDX_CFG1] = 8'($random(seed));
    m0 = mem[`OPT_IDX_CFG0] & 8'hbf;
    m1 = mem[`OPT_IDX_CFG1];
    mt = mem[`OPT_IDX_TRIM];
    rd_cyc.delete();
    rd_addr.delete();
    i_resetn = 1'b1;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_load_done !== 1'b1 && n < 20);
    chk8(8'(n), 8'd9, "load length");
    chk8(8'(rd_cyc.size()), 8'd3, "read count");
    for (int k = 0; k < rd_cyc.size() && k < 3; k++) begin
      chk8(8'(rd_cyc[k]), 8'(1 + 3 * k), "read slot");
      chk8(rd_addr[k], k == 0 ? `OPT_IDX_TRIM :
           k == 1 ? `OPT_IDX_CFG0 : `OPT_IDX_CFG1, "read addr");
    end
    chk_out();
  endtask

  task automatic tick_gap(output int n);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_sys_clk_tick !== 1'b1 && n < 30);
  endtask

  // ------------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    #(20 * 5000);
    fails++;
    test_done();
  end

  initial begin
    int g;
    logic [7:0] v;
    logic [16:0] cs [6];
    fails = 0;
    n_tests = 0;
    seed = 32'h3613;
    i_resetn = 1'b0;
    sfr_in = '0;
    movc_in = '0;
    reset_pin = 1'b1;
    nvm_rdata = 8'h00;
    do_reset();
    // every mapped index, bit six forced high, and an unmapped one
    wrreg(`OPT_IDX_CFG0, 8'h40 | 8'(m0));
    wrreg(`OPT_IDX_TRIM, 8'($random(seed)));
    wrreg(`OPT_IDX_CFG1, 8'($random(seed)));
    wrreg(8'h55, 8'hff);
    rdreg(`OPT_IDX_CFG0);
    rdreg(`OPT_IDX_CFG1);
    rdreg(`OPT_IDX_TRIM);
    rdreg(8'h55);
    chk_out();
    // every divide code, gap measured after two ticks have settled
    for (int c = 0; c < 4; c++) begin
      v = 8'($random(seed));
      wrreg(`OPT_IDX_CFG0, {v[7:6], 2'(c), 1'b0, v[2:0]});
      tick_gap(g);
      tick_gap(g);
      tick_gap(g);
      chk8(8'(g), c == 0 ? 8'd1 : c == 1 ? 8'd2 :
           c == 2 ? 8'd4 : 8'd12, "divide");
      chk_out();
    end
    // pin as reset input, then as general input
    reset_pin = 1'b0;
    repeat (6) @(negedge i_clk);
    chk8({6'h0, o_ext_reset_req, o_gpio_in}, 8'h02, "pin rst");
    wrreg(`OPT_IDX_CFG0, m0 | 8'h08);
    chk8({6'h0, o_ext_reset_req, o_gpio_in}, 8'h00, "gpio lo");
    reset_pin = 1'b1;
    repeat (6) @(negedge i_clk);
    chk8({6'h0, o_ext_reset_req, o_gpio_in}, 8'h01, "gpio hi");
    // guard cases back to back: exec, target, addr, expected verdict
    cs[0] = {1'b0, 1'b0, 14'h00ff, 1'b1};
    cs[1] = {1'b0, 1'b0, 14'h0100, 1'b0};
    cs[2] = {1'b0, 1'b1, 14'h0200, 1'b1};
    cs[3] = {1'b1, 1'b1, 14'h0010, 1'b0};
    cs[4] = {1'b1, 1'b0, 14'h0000, 1'b0};
    cs[5] = {1'b0, 1'b0, 14'h0100 | 14'($random(seed)), 1'b0};
    for (int k = 0; k < 6; k++) begin
      movc_in = '{req: 1'b1, exec_loader: cs[k][16],
                  target_loader: cs[k][15], addr: cs[k][14:1]};
      @(negedge i_clk);
      chk8({6'h0, o_movc_valid, o_movc_blocked},
           {6'h0, 1'b1, cs[k][0]}, "guard");
    end
    movc_in = '0;
    @(negedge i_clk);
    chk8({7'h0, o_movc_valid}, 8'h00, "guard idle");
    // second reset in mid-run reloads new storage contents
    do_reset();
    rdreg(`OPT_IDX_CFG0);
    test_done();
  end

endmodule
